/* hdl/rcss_top.sv */
// Behaviour
// - Bytes shift most significant bit first; this port is always slave.
// - Select must stay low; rising mid header or register byte cancels transfer.
// - Data out goes low at select fall, or once oscillator is stable.
// - A status byte shifts out while each header, write data byte or strobe shifts in; read bytes return register data, except queue reads, which return status.
// - Status bit 7 is not ready, high until the oscillator is stable.
// - Status bits 6:4 encode transmit, fast ready, calibrate, settle, underrun.
// - Transitional calibrate or settle may report idle instead.
// - Underrun is reported until the host issues the flush strobe.
// - Status bits 3:0 give free queue space, valid for write headers.
// - Free space count saturates at 15.
// - Reset loads defaults; host then programs what must differ.
// - Burst loads header address; a register burst steps it after every byte, a queue burst keeps 3Fh.
// - Addresses 30h to 3Dh: burst reads status, otherwise command strobe.
// - Header 3Fh writes one queue byte; 7Fh writes until select rises.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "rcss_regs.svh"

`default_nettype none

module rcss_top #(
    parameter int FREE_W        = 7,
    parameter bit TRANS_AS_IDLE = 1'b1
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 sclk_pin,
    input  wire logic                 sel_b_pin,
    input  wire logic                 sdi_pin,
    output logic                      sdo_ff,
    output logic                      sdo_oe_ff,
    input  wire logic                 osc_stable,
    input  wire rcss_pkg::rcss_mode_t radio_mode,
    input  wire logic                 mode_transitional,
    input  wire logic                 underflow_evt,
    input  wire logic [FREE_W-1:0]    tx_free,
    input  wire logic [7:0]           reg_rdata,
    output logic [5:0]                reg_addr_ff,
    output logic [7:0]                wdata_ff,
    output logic                      reg_wr_ff,
    output logic                      reg_rd_ff,
    output logic                      stat_rd_ff,
    output logic                      strobe_ff,
    output logic                      fifo_wr_ff,
    output logic                      underrun_ff,
    output logic                      abort_ff,
    output logic                      release_ff
);
    import rcss_pkg::*;

    // Pins cross two flip-flops before any use
    rcss_pin_if pins ();

    rcss_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .sclk_pin  (sclk_pin),
        .sel_b_pin (sel_b_pin),
        .sdi_pin   (sdi_pin),
        .pins      (pins.src)
    );

    rcss_xfer_t xfer_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] rx_sr_ff;
    logic [7:0] tx_sr_ff;
    logic [7:0] rd_buf_ff;
    logic       load_ff;
    logic       rd_data_ff;
    logic       rd_cap_ff;
    logic       started_ff;
    logic       rw_ff;
    logic       burst_ff;
    logic       step_ff;

    // Decode of the byte completing on this rise
    logic [7:0] rx_byte;
    logic [7:0] status;
    logic       byte_done;
    logic       hdr_done;
    logic       data_done;
    logic       hdr_stat;
    logic       hdr_fifo;
    logic       hdr_rd;
    logic       hdr_strobe;

    function automatic logic in_stat(input logic [5:0] a);
        return (a >= `RCSS_STAT_LO) && (a <= `RCSS_STAT_HI);
    endfunction : in_stat

    // Address field of a header byte
    function automatic logic [5:0] hdr_addr(input logic [7:0] b);
        return b[`RCSS_HDR_ADDR_HI:0];
    endfunction : hdr_addr

    // Select rise cancels these transfers mid byte
    function automatic logic cancels(input rcss_xfer_t x);
        return (x == XF_HDR) || (x == XF_REG) || (x == XF_STAT);
    endfunction : cancels

    // Counts of fifteen or more read as fifteen
    function automatic logic [3:0] free_sat(input logic [FREE_W-1:0] n);
        if (n >= FREE_W'(`RCSS_FREE_MAX)) begin
            return `RCSS_FREE_MAX;
        end
        return n[3:0];
    endfunction : free_sat

    // Underrun outranks the radio mode until flushed
    function automatic logic [2:0] state_code(
        input rcss_mode_t m,
        input logic       trans,
        input logic       undr
    );
        logic quiet;
        quiet = TRANS_AS_IDLE & trans;
        if (undr) begin
            return `RCSS_CODE_UNDR;
        end
        unique case (m)
            RCSS_MODE_IDLE:   return `RCSS_CODE_IDLE;
            RCSS_MODE_TX:     return `RCSS_CODE_TX;
            RCSS_MODE_FSTX:   return `RCSS_CODE_FSTX;
            RCSS_MODE_CAL:    return quiet ? `RCSS_CODE_IDLE : `RCSS_CODE_CAL;
            RCSS_MODE_SETTLE: return quiet ? `RCSS_CODE_IDLE : `RCSS_CODE_SETTLE;
            default:          return `RCSS_CODE_IDLE;
        endcase
    endfunction : state_code

    // Byte framing and header decode
    assign rx_byte   = {rx_sr_ff[6:0], pins.sdi};
    assign byte_done = pins.sclk_rise & (bit_cnt_ff == `RCSS_BIT_LAST);
    assign hdr_done  = byte_done & (xfer_ff == XF_HDR);
    assign data_done = byte_done & (xfer_ff != XF_HDR) & (xfer_ff != XF_IDLE);
    assign hdr_stat  = in_stat(hdr_addr(rx_byte));
    assign hdr_fifo  = hdr_addr(rx_byte) == `RCSS_FIFO_ADDR;
    assign hdr_strobe = hdr_stat & ~rx_byte[`RCSS_HDR_BURST];
    // Queue reads and strobes fetch nothing
    assign hdr_rd    = rx_byte[`RCSS_HDR_RW] & ~hdr_fifo & ~hdr_strobe;

    // Live status byte
    always_comb begin
        status = {~osc_stable,
                  state_code(radio_mode, mode_transitional, underrun_ff),
                  free_sat(tx_free)};
    end

    // Transfer state machine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xfer_ff    <= XF_IDLE;
            bit_cnt_ff <= `RCSS_BIT_FIRST;
            rx_sr_ff   <= `RCSS_BYTE_ZERO;
            rw_ff      <= 1'b0;
            burst_ff   <= 1'b0;
        end else if (!pins.sel_low) begin
            xfer_ff    <= XF_IDLE;
            bit_cnt_ff <= `RCSS_BIT_FIRST;
        end else if (xfer_ff == XF_IDLE) begin
            xfer_ff    <= XF_HDR;
            bit_cnt_ff <= `RCSS_BIT_FIRST;
        end else if (pins.sclk_rise) begin
            rx_sr_ff   <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + `RCSS_BIT_STEP;
            if (byte_done) begin
                unique case (xfer_ff)
                    XF_IDLE: begin
                        xfer_ff <= XF_HDR;
                    end
                    XF_HDR: begin
                        rw_ff    <= rx_byte[`RCSS_HDR_RW];
                        burst_ff <= rx_byte[`RCSS_HDR_BURST];
                        if (hdr_stat) begin
                            // Burst bit picks status read, else a strobe
                            xfer_ff <= rx_byte[`RCSS_HDR_BURST] ? XF_STAT
                                                                : XF_HDR;
                        end else if (hdr_fifo) begin
                            xfer_ff <= XF_FIFO;
                        end else begin
                            xfer_ff <= XF_REG;
                        end
                    end
                    XF_REG: begin
                        if (!burst_ff) begin
                            xfer_ff <= XF_HDR;
                        end
                    end
                    XF_FIFO: begin
                        if (!burst_ff) begin
                            xfer_ff <= XF_HDR;
                        end
                    end
                    XF_STAT: begin
                        xfer_ff <= XF_HDR;
                    end
                endcase
            end
        end
    end

    // Burst address counter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_addr_ff <= `RCSS_ADDR_ZERO;
            step_ff     <= 1'b0;
        end else begin
            // Step one cycle after the byte so the write sees the old address
            step_ff <= data_done & burst_ff & (xfer_ff == XF_REG);
            if (hdr_done) begin
                reg_addr_ff <= hdr_addr(rx_byte);
            end else if (step_ff) begin
                reg_addr_ff <= reg_addr_ff + `RCSS_ADDR_STEP;
            end
        end
    end

    // Access pulses towards the register file, strobes and queue
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_ff   <= `RCSS_BYTE_ZERO;
            reg_wr_ff  <= 1'b0;
            reg_rd_ff  <= 1'b0;
            stat_rd_ff <= 1'b0;
            strobe_ff  <= 1'b0;
            fifo_wr_ff <= 1'b0;
        end else begin
            reg_wr_ff  <= data_done & ~rw_ff & (xfer_ff == XF_REG);
            fifo_wr_ff <= data_done & ~rw_ff & (xfer_ff == XF_FIFO);
            strobe_ff  <= hdr_done & hdr_stat
                        & ~rx_byte[`RCSS_HDR_BURST];
            stat_rd_ff <= hdr_done & hdr_stat
                        & rx_byte[`RCSS_HDR_BURST];
            // Reads prefetch the next address in a burst
            reg_rd_ff  <= (hdr_done & hdr_rd & ~hdr_stat)
                        | (step_ff & rw_ff);
            if (data_done) begin
                wdata_ff <= rx_byte;
            end
        end
    end

    // Read data capture, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_cap_ff <= 1'b0;
            rd_buf_ff <= `RCSS_BYTE_ZERO;
        end else begin
            rd_cap_ff <= reg_rd_ff | stat_rd_ff;
            if (rd_cap_ff) begin
                rd_buf_ff <= reg_rdata;
            end
        end
    end

    // Outgoing shift register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sr_ff   <= `RCSS_BYTE_ZERO;
            load_ff    <= 1'b0;
            rd_data_ff <= 1'b0;
            started_ff <= 1'b0;
        end else if (!pins.sel_low) begin
            load_ff    <= 1'b0;
            rd_data_ff <= 1'b0;
            started_ff <= 1'b0;
        end else if (xfer_ff == XF_IDLE) begin
            // Idle cycle loads the status for the header
            tx_sr_ff   <= status;
            started_ff <= 1'b0;
        end else if (pins.sclk_rise) begin
            started_ff <= 1'b1;
            if ((xfer_ff == XF_HDR) && (bit_cnt_ff == `RCSS_BIT_FIRST)) begin
                // Free count only for write headers
                tx_sr_ff[`RCSS_ST_FREE_HI:0] <= pins.sdi ? `RCSS_FREE_NONE
                                                         : free_sat(tx_free);
            end
            if (byte_done) begin
                load_ff    <= 1'b1;
                rd_data_ff <= hdr_done ? hdr_rd
                                       : (rw_ff & burst_ff & (xfer_ff == XF_REG));
            end
        end else if (pins.sclk_fall) begin
            // Mode 0: the next bit goes out on the falling edge
            if (load_ff) begin
                tx_sr_ff <= rd_data_ff ? rd_buf_ff : status;
                load_ff  <= 1'b0;
            end else begin
                tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
            end
        end
    end

    // Data out pin: ready level before the first clock, then shifted bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else if (!pins.sel_low) begin
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_oe_ff <= 1'b1;
            if (!started_ff) begin
                sdo_ff <= ~osc_stable;
            end else begin
                sdo_ff <= tx_sr_ff[`RCSS_ST_RDY];
            end
        end
    end

    // Underrun flag: the event wins over the flush strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            underrun_ff <= 1'b0;
        end else if (underflow_evt) begin
            underrun_ff <= 1'b1;
        end else if (strobe_ff && (reg_addr_ff == `RCSS_FLUSH_ADDR)) begin
            underrun_ff <= 1'b0;
        end
    end

    // Select release events
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            abort_ff   <= 1'b0;
            release_ff <= 1'b0;
        end else begin
            // Release also lets deferred strobes run
            release_ff <= pins.sel_rise;
            abort_ff   <= pins.sel_rise & (bit_cnt_ff != `RCSS_BIT_FIRST)
                        & cancels(xfer_ff);
        end
    end
endmodule : rcss_top

`default_nettype wire

/* hdl/rcss_regs.svh */
`ifndef RCSS_REGS_SVH
`define RCSS_REGS_SVH

// Header byte fields
`define RCSS_HDR_RW       7
`define RCSS_HDR_BURST    6
`define RCSS_HDR_ADDR_HI  5

// Status byte fields
`define RCSS_ST_RDY       7
`define RCSS_ST_STATE_HI  6
`define RCSS_ST_STATE_LO  4
`define RCSS_ST_FREE_HI   3

// Address map
`define RCSS_STAT_LO      6'h30
`define RCSS_STAT_HI      6'h3D
`define RCSS_FIFO_ADDR    6'h3F
`define RCSS_FLUSH_ADDR   6'h3B

// Status state codes
`define RCSS_CODE_IDLE    3'h0
`define RCSS_CODE_TX      3'h2
`define RCSS_CODE_FSTX    3'h3
`define RCSS_CODE_CAL     3'h4
`define RCSS_CODE_SETTLE  3'h5
`define RCSS_CODE_UNDR    3'h7

// Counts and reset values
`define RCSS_FREE_MAX     4'hF
`define RCSS_FREE_NONE    4'h0
`define RCSS_BIT_FIRST    3'h0
`define RCSS_BIT_LAST     3'h7
`define RCSS_BIT_STEP     3'h1
`define RCSS_ADDR_STEP    6'h01
`define RCSS_BYTE_ZERO    8'h00
`define RCSS_ADDR_ZERO    6'h00

`endif

/* hdl/rcss_pkg.sv */
`default_nettype none

package rcss_pkg;

    typedef enum logic [2:0] {
        RCSS_MODE_IDLE,
        RCSS_MODE_TX,
        RCSS_MODE_FSTX,
        RCSS_MODE_CAL,
        RCSS_MODE_SETTLE
    } rcss_mode_t;

    typedef enum logic [2:0] {
        XF_IDLE,
        XF_HDR,
        XF_REG,
        XF_FIFO,
        XF_STAT
    } rcss_xfer_t;

endpackage : rcss_pkg

`default_nettype wire

/* hdl/rcss_pin_if.sv */
`default_nettype none

interface rcss_pin_if;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_low;
    logic sel_rise;
    logic sdi;

    modport src (
        output sclk_rise,
        output sclk_fall,
        output sel_low,
        output sel_rise,
        output sdi
    );

    modport dst (
        input sclk_rise,
        input sclk_fall,
        input sel_low,
        input sel_rise,
        input sdi
    );
endinterface : rcss_pin_if

`default_nettype wire

/* hdl/rcss_pin_sync.sv */
`default_nettype none

module rcss_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic sclk_pin,
    input  wire logic sel_b_pin,
    input  wire logic sdi_pin,
    rcss_pin_if.src   pins
);
    // Stage 1 feeds only stage 2; stage 3 is for edges
    logic [2:0] sclk_ff;
    logic [2:0] sel_b_ff;
    logic [1:0] sdi_ff;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_ff  <= 3'h0;
            sel_b_ff <= 3'h7;
            sdi_ff   <= 2'h0;
        end else begin
            sclk_ff  <= {sclk_ff[1:0], sclk_pin};
            sel_b_ff <= {sel_b_ff[1:0], sel_b_pin};
            sdi_ff   <= {sdi_ff[0], sdi_pin};
        end
    end

    assign pins.sclk_rise = sclk_ff[1] & ~sclk_ff[2];
    assign pins.sclk_fall = ~sclk_ff[1] & sclk_ff[2];
    assign pins.sel_low   = ~sel_b_ff[1];
    assign pins.sel_rise  = sel_b_ff[1] & ~sel_b_ff[2];
    assign pins.sdi       = sdi_ff[1];
endmodule : rcss_pin_sync

`default_nettype wire

/* sim/rcss_top_properties.sv */
`include "rcss_regs.svh"
`default_nettype none
module rcss_top_properties (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       sel_b_pin,
    input wire logic       osc_stable,
    input wire logic       underflow_evt,
    input wire logic       sdo_ff,
    input wire logic       sdo_oe_ff,
    input wire logic [5:0] reg_addr_ff,
    input wire logic       reg_wr_ff,
    input wire logic       reg_rd_ff,
    input wire logic       stat_rd_ff,
    input wire logic       strobe_ff,
    input wire logic       fifo_wr_ff,
    input wire logic       underrun_ff,
    input wire logic       release_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic stat_a;
    assign stat_a = reg_addr_ff >= `RCSS_STAT_LO && reg_addr_ff <= `RCSS_STAT_HI;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_sel_held;
        $fell(sel_b_pin) ##1 !sel_b_pin [*3];
    endsequence
    sequence s_flush;
        strobe_ff && reg_addr_ff == `RCSS_FLUSH_ADDR && !underflow_evt;
    endsequence
    property p_oe_on; s_sel_held |-> ##[0:1] sdo_oe_ff; endproperty
    property p_rdy_low; $rose(sdo_oe_ff) && $past(osc_stable) |-> !sdo_ff; endproperty
    property p_rdy_high; $rose(sdo_oe_ff) && !$past(osc_stable) |-> sdo_ff; endproperty
    property p_excl; $onehot0({reg_wr_ff, reg_rd_ff, stat_rd_ff, strobe_ff, fifo_wr_ff}); endproperty
    property p_stat_map; stat_rd_ff || strobe_ff |-> stat_a; endproperty
    property p_reg_map; reg_wr_ff || reg_rd_ff |-> !stat_a && reg_addr_ff != `RCSS_FIFO_ADDR; endproperty
    property p_fifo_map; fifo_wr_ff |-> reg_addr_ff == `RCSS_FIFO_ADDR; endproperty
    property p_undr_set; underflow_evt |=> underrun_ff; endproperty
    property p_undr_clr; s_flush |=> !underrun_ff; endproperty
    property p_undr_hold; underrun_ff && !strobe_ff |=> underrun_ff; endproperty
    property p_release; $rose(sel_b_pin) |-> ##[1:5] release_ff; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output enable late");
    a_rdy_low: assert property (p_rdy_low) else $error("data out not low");
    a_rdy_high: assert property (p_rdy_high) else $error("not ready low");
    a_excl: assert property (p_excl) else $error("two pulses at once");
    a_stat_map: assert property (p_stat_map) else $error("status address");
    a_reg_map: assert property (p_reg_map) else $error("register address");
    a_fifo_map: assert property (p_fifo_map) else $error("queue address");
    a_undr_set: assert property (p_undr_set) else $error("underrun not set");
    a_undr_clr: assert property (p_undr_clr) else $error("underrun not cleared");
    a_undr_hold: assert property (p_undr_hold) else $error("underrun lost");
    a_release: assert property (p_release) else $error("no release pulse");
endmodule : rcss_top_properties
`default_nettype wire

/* sim/rcss_host.sv */
`default_nettype none
module rcss_host (
    output logic     sclk,
    output logic     sel_b,
    output logic     sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        sel_b = 1'b1;
        sdi = 1'b0;
    end
    task automatic open_frame(output bit ok);
        ok = 1'b0;
        #1;
        sel_b = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            #25;
            ok = !sdo;
        end
    endtask : open_frame
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sdi = tx[i];
            #62.5;
            rx[i] = sdo;
            sclk = 1'b1;
            #62.5;
            sclk = 1'b0;
        end
        #100;
    endtask : shift
    task automatic close_frame();
        #20;
        sel_b = 1'b1;
        sdi = ~sdi;
        #300;
    endtask : close_frame
endmodule : rcss_host
`default_nettype wire

/* sim/rcss_top_bench.sv */
`include "rcss_regs.svh"
`default_nettype none
module rcss_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rcss_pkg::*;
    logic        ref_clk, rst_b, osc_stable, mode_transitional, underflow_evt, undr;
    logic        sclk_pin, sel_b_pin, sdi_pin, sdo_ff, sdo_oe_ff, sdo_w;
    logic        reg_wr_ff, reg_rd_ff, stat_rd_ff, strobe_ff, fifo_wr_ff;
    logic        underrun_ff, abort_ff, release_ff;
    rcss_mode_t  radio_mode;
    logic [6:0]  tx_free;
    logic [7:0]  reg_rdata, wdata_ff, rx;
    logic [5:0]  reg_addr_ff;
    logic [16:0] exp_q[$];
    int          fails, comparisons, seed;
    bit          ok;
    rcss_top dut_u (.ref_clk, .rst_b, .sclk_pin, .sel_b_pin, .sdi_pin, .sdo_ff, .sdo_oe_ff,
        .osc_stable, .radio_mode, .mode_transitional, .underflow_evt, .tx_free, .reg_rdata,
        .reg_addr_ff, .wdata_ff, .reg_wr_ff, .reg_rd_ff, .stat_rd_ff, .strobe_ff, .fifo_wr_ff,
        .underrun_ff, .abort_ff, .release_ff);
    rcss_host host_u (.sclk(sclk_pin), .sel_b(sel_b_pin), .sdi(sdi_pin), .sdo(sdo_w));
    // Pull-up on data out while not driven
    assign sdo_w = sdo_oe_ff === 1'b1 ? sdo_ff : 1'b1;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) reg_rdata <= {2'b10, reg_addr_ff};
    always @(posedge ref_clk) begin
        if (abort_ff === 1'b1) begin
            check_ev({3'h6, 14'h0000});
        end else if ((reg_wr_ff | reg_rd_ff | stat_rd_ff | strobe_ff | fifo_wr_ff) === 1'b1) begin
            check_ev({reg_wr_ff ? 3'h1 : reg_rd_ff ? 3'h2 : stat_rd_ff ? 3'h3 : strobe_ff ? 3'h4
                : 3'h5, reg_addr_ff, (reg_wr_ff | fifo_wr_ff) ? wdata_ff : 8'h00});
        end
    end
    task automatic check_ev(input logic [16:0] got);
        comparisons++;
        if (exp_q.size() == 0 || exp_q[0] !== got) begin
            fails++;
            $display("unexpected at %0t: event %h", $time, got);
        end
        if (exp_q.size() != 0) begin
            void'(exp_q.pop_front());
        end
    endtask : check_ev
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_byte
    function automatic logic [7:0] stat(input logic rw);
        logic [2:0] c;
        case (radio_mode)
            RCSS_MODE_TX:     c = `RCSS_CODE_TX;
            RCSS_MODE_FSTX:   c = `RCSS_CODE_FSTX;
            RCSS_MODE_CAL:    c = mode_transitional ? `RCSS_CODE_IDLE : `RCSS_CODE_CAL;
            RCSS_MODE_SETTLE: c = mode_transitional ? `RCSS_CODE_IDLE : `RCSS_CODE_SETTLE;
            default:          c = `RCSS_CODE_IDLE;
        endcase
        if (undr) begin
            c = `RCSS_CODE_UNDR;
        end
        return {~osc_stable, c, rw ? 4'h0 : tx_free > 7'h0F ? 4'hF : tx_free[3:0]};
    endfunction : stat
    task automatic xfer(input logic [7:0] tx, input logic [7:0] exp);
        host_u.shift(tx, 8, rx);
        check_byte(rx, exp);
    endtask : xfer
    task automatic frame_begin();
        host_u.open_frame(ok);
        check_byte({7'h00, ok}, 8'h01);
    endtask : frame_begin
    task automatic frame_end();
        host_u.close_frame();
        repeat (20) @(posedge ref_clk);
    endtask : frame_end
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #500us;
        fails++;
        end_of_test();
    end
    initial begin
        seed = 32'h9D2D7429;
        {rst_b, osc_stable, mode_transitional, underflow_evt, undr} = 5'h08;
        radio_mode = RCSS_MODE_IDLE;
        tx_free = 7'h0E;
        fails = 0;
        comparisons = 0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            radio_mode <= rcss_mode_t'(3'(i % 5));
            mode_transitional <= i >= 5;
            tx_free <= i < 2 ? 7'h0F - 7'(i) : 7'($random(seed));
            @(posedge ref_clk);
            frame_begin();
            exp_q.push_back({3'h4, 6'h36, 8'h00});
            xfer({i[0], 7'h36}, stat(i[0]));
            frame_end();
        end
        $display("status test done");
        radio_mode <= RCSS_MODE_IDLE;
        @(posedge ref_clk);
        frame_begin();
        exp_q.push_back({3'h1, 6'h05, 8'hA5});
        exp_q.push_back({3'h2, 6'h05, 8'h00});
        xfer(8'h05, stat(1'b0));
        xfer(8'hA5, stat(1'b0));
        xfer(8'h85, stat(1'b1));
        xfer(8'h00, 8'h85);
        xfer(8'h4A, stat(1'b0));
        for (int k = 0; k < 3; k++) begin
            exp_q.push_back({3'h1, 6'h0A + 6'(k), 8'hC0 | 8'(k)});
            xfer(8'hC0 | 8'(k), stat(1'b0));
        end
        frame_end();
        for (int k = 0; k < 3; k++) begin
            exp_q.push_back({3'h2, 6'h10 + 6'(k), 8'h00});
        end
        frame_begin();
        xfer(8'hD0, stat(1'b1));
        for (int k = 0; k < 2; k++) begin
            xfer(8'h00, {2'b10, 6'h10 + 6'(k)});
        end
        frame_end();
        $display("register test done");
        frame_begin();
        exp_q.push_back({3'h5, 6'h3F, 8'h5A});
        xfer(8'h3F, stat(1'b0));
        xfer(8'h5A, stat(1'b0));
        xfer(8'h7F, stat(1'b0));
        for (int k = 0; k < 3; k++) begin
            exp_q.push_back({3'h5, 6'h3F, 8'h70 | 8'(k)});
            xfer(8'h70 | 8'(k), stat(1'b0));
        end
        frame_end();
        exp_q.push_back({3'h3, 6'h34, 8'h00});
        frame_begin();
        xfer(8'hF4, stat(1'b1));
        xfer(8'h00, 8'hB4);
        frame_end();
        $display("queue test done");
        frame_begin();
        xfer(8'h05, stat(1'b0));
        exp_q.push_back({3'h6, 14'h0000});
        host_u.shift(8'hFF, 4, rx);
        frame_end();
        $display("abort test done");
        underflow_evt <= 1'b1;
        @(posedge ref_clk);
        underflow_evt <= 1'b0;
        undr = 1'b1;
        repeat (2) @(posedge ref_clk);
        frame_begin();
        exp_q.push_back({3'h4, 6'h3B, 8'h00});
        xfer(8'h3B, stat(1'b0));
        undr = 1'b0;
        exp_q.push_back({3'h4, 6'h36, 8'h00});
        xfer(8'h36, stat(1'b0));
        frame_end();
        $display("underrun test done");
        osc_stable <= 1'b0;
        @(posedge ref_clk);
        fork
            frame_begin();
            begin
                repeat (40) @(posedge ref_clk);
                check_byte({7'h00, sdo_w}, 8'h01);
                osc_stable <= 1'b1;
            end
        join
        exp_q.push_back({3'h4, 6'h36, 8'h00});
        xfer(8'h36, stat(1'b0));
        frame_end();
        $display("ready test done");
        check_byte(8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule : rcss_top_bench
bind rcss_top rcss_top_properties chk_u (.ref_clk, .rst_b, .sel_b_pin, .osc_stable,
    .underflow_evt, .sdo_ff, .sdo_oe_ff, .reg_addr_ff, .reg_wr_ff, .reg_rd_ff, .stat_rd_ff,
    .strobe_ff, .fifo_wr_ff, .underrun_ff, .release_ff);
`default_nettype wire
